// ### core/dap_port.sv
// Purpose: digital side of a two channel 14-bit converter: configuration port and sample output buses
// Assumes: samples and range bits arrive from the converter core synchronous to pclk
// Notes: the encode clock is a pin sampled by pclk, so it must run well below pclk/2
//
// Overview of operation
// RULE_01: strap low serial port, high parallel pins
// RULE_02: serial bits shift only while cs low
// RULE_03: sdi captured on rising serial clock edge
// RULE_04: readback shifted on sdo, host samples falling
// RULE_05: sdo open drain, only pulls low
// RULE_06: parallel cs level enables duty stabilizer
// RULE_07: parallel sck level selects output mode
// RULE_08: parallel sdi and sdo select power down
// RULE_09: conversion starts on rising encode edge
// RULE_10: grounded encode complement selects single-ended mode
// RULE_11: full rate: 14 bits, bit 13 msb
// RULE_12: full rate data changes on clock fall
// RULE_13: ddr data changes on both clock edges
// RULE_14: forwarded clock phase programmable by register
// RULE_15: ddr seven lanes, even low, odd high
// RULE_16: full rate per channel range flag
// RULE_17: ddr shared flag: ch2 low, ch1 high
// RULE_18: lvds current and termination programmable
// RULE_19: latency six cycles full, 6.5 ddr; ddr here is taken at DDR_TAP, a whole cycle behind full rate
// RULE_20: frame is rw, address, byte, msb first
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dap_port (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         program_mode_strap,
   input  wire logic                         cs_n,
   input  wire logic                         sck,
   input  wire logic                         sdi,
   input  wire logic                         sdo_i,
   output logic                              sdo_o,
   output logic                              sdo_oe_n,
   input  wire logic                         encode_clock_pos,
   input  wire logic                         encode_clock_neg,
   input  wire logic [dap_pkg::SAMPLE_W-1:0] ch1_sample_in,
   input  wire logic [dap_pkg::SAMPLE_W-1:0] ch2_sample_in,
   input  wire logic                         ch1_range_in,
   input  wire logic                         ch2_range_in,
   output logic      [dap_pkg::SAMPLE_W-1:0] ch1_sample_bus,
   output logic      [dap_pkg::SAMPLE_W-1:0] ch2_sample_bus,
   output logic      [dap_pkg::LANES-1:0]    ch1_pair_lanes,
   output logic      [dap_pkg::LANES-1:0]    ch2_pair_lanes,
   output logic                              ch1_range_flag,
   output logic                              ch2_range_flag,
   output logic                              shared_range_flag,
   output logic                              forwarded_clock_pos,
   output logic                              forwarded_clock_neg,
   output dap_pkg::dap_mode_t                output_mode,
   output logic                              duty_stabilizer_en,
   output logic      [1:0]                   power_down,
   output logic      [2:0]                   lvds_current,
   output logic                              lvds_term_en
);
   import dap_pkg::*;

   // pin order in the synchroniser: strap, cs_n, sck, sdi, sdo_i, enc+, enc-
   typedef struct packed {
      logic [6:0]                          sync1;
      logic [6:0]                          sync2;
      logic                                sck_prev;
      logic                                enc_prev;
      logic [5:0]                          se_cnt;
      logic [3:0]                          spi_cnt;
      logic [7:0]                          spi_sh;
      logic                                spi_rd;
      logic [6:0]                          spi_addr;
      logic                                sdo_drive;
      logic [7:0]                          ctrl;
      logic [7:0]                          outr;
      logic [PIPE_N-1:0][SAMPLE_W-1:0]     p1;
      logic [PIPE_N-1:0][SAMPLE_W-1:0]     p2;
      logic [PIPE_N-1:0]                   r1;
      logic [PIPE_N-1:0]                   r2;
      logic [SAMPLE_W-1:0]                 bus1;
      logic [SAMPLE_W-1:0]                 bus2;
      logic [LANES-1:0]                    lane1;
      logic [LANES-1:0]                    lane2;
      logic                                f1;
      logic                                f2;
      logic                                fs;
      logic [2:0]                          clk_line;
      logic                                fclk;
      logic [31:0]                         rdata;
   } dap_state_t;

   dap_state_t s_q;
   dap_state_t s_d;

   logic       par;
   logic       cs_l;
   logic       sck_l;
   logic       sdi_l;
   logic       sdo_l;
   logic       single_ended;
   logic       enc_lvl;
   logic       enc_rise;
   logic       enc_fall;
   logic       sck_rise;
   logic       sck_fall;
   logic [1:0] phase;
   logic       apb_wr;
   logic [6:0] apb_idx;
   logic       apb_hit;
   dap_mode_t  mode_eff;
   logic [7:0] rb_byte;
   logic       rb_bit;

   function automatic logic [7:0] reg_read(input logic [6:0] idx, input dap_state_t s,
                                           input dap_mode_t m, input logic se);
      logic [7:0] v;
      v = 8'h00;
      if (idx == REG_CTRL) begin
         v = s.ctrl;
      end else if (idx == REG_OUTPUT) begin
         v = s.outr;
      end else if (idx == REG_STATUS) begin
         v = {1'b0, duty_stabilizer_en, power_down, m, se, s.sync2[6]};
      end
      return v;
   endfunction

   assign par     = s_q.sync2[6];
   assign cs_l    = s_q.sync2[5];
   assign sck_l   = s_q.sync2[4];
   assign sdi_l   = s_q.sync2[3];
   assign sdo_l   = s_q.sync2[2];
   assign single_ended = (s_q.se_cnt == SE_DETECT_CYCLES);    // [RULE_10]
   // differential mode: the edge is ENC+ rising while ENC- falls
   assign enc_lvl  = single_ended ? s_q.sync2[1] : (s_q.sync2[1] & ~s_q.sync2[0]);
   assign enc_rise = enc_lvl & ~s_q.enc_prev;                  // [RULE_09]
   assign enc_fall = ~enc_lvl & s_q.enc_prev;
   assign sck_rise = sck_l & ~s_q.sck_prev;
   assign sck_fall = ~sck_l & s_q.sck_prev;

   // readback byte decoded once; the bit index walks msb first
   always_comb begin
      rb_byte = reg_read(s_q.spi_addr, s_q, mode_eff, single_ended);
   end
   assign rb_bit = rb_byte[3'(4'hf - s_q.spi_cnt)];

   // parallel pins take over the reduced mode set
   always_comb begin
      if (par) begin
         mode_eff           = sck_l ? om_ddr_lvds : om_full;     // [RULE_07] [RULE_01]
         duty_stabilizer_en = cs_l;                             // [RULE_06]
         power_down         = {sdi_l, sdo_l};                   // [RULE_08]
         phase              = 2'b00;
      end else begin
         case (s_q.outr[OUT_MODE_LSB +: 2])
            2'b01:   mode_eff = om_ddr_cmos;
            2'b10:   mode_eff = om_ddr_lvds;
            default: mode_eff = om_full;
         endcase
         duty_stabilizer_en = s_q.ctrl[CTRL_DCS];
         power_down         = s_q.ctrl[CTRL_PD_LSB +: 2];
         phase              = s_q.outr[OUT_PHASE_LSB +: 2];      // [RULE_14]
      end
   end

   assign output_mode  = mode_eff;
   assign lvds_current = s_q.outr[OUT_CUR_LSB +: 3];            // [RULE_18]
   assign lvds_term_en = s_q.outr[OUT_TERM] & (mode_eff == om_ddr_lvds);

   assign apb_idx = {1'b0, paddr[7:2]};
   assign apb_hit = (paddr[1:0] == 2'b00) && (paddr[7:2] <= 6'(REG_STATUS));
   assign apb_wr  = psel & penable & pwrite & apb_hit;

   always_comb begin
      s_d = s_q;
      s_d.sync1    = {program_mode_strap, cs_n, sck, sdi, sdo_i, encode_clock_pos, encode_clock_neg};
      s_d.sync2    = s_q.sync1;
      s_d.sck_prev = sck_l;
      s_d.enc_prev = enc_lvl;
      if (s_q.sync2[0]) begin
         s_d.se_cnt = 6'h00;
      end else if (!single_ended) begin
         s_d.se_cnt = s_q.se_cnt + 6'h01;
      end

      // bus writes first so a completed serial byte overrides in the same cycle
      if (apb_wr && apb_idx == REG_CTRL) begin
         s_d.ctrl = pwdata[7:0];
      end else if (apb_wr && apb_idx == REG_OUTPUT) begin
         s_d.outr = pwdata[7:0];
      end
      // refused access reads zero
      if (psel && !penable) begin
         s_d.rdata = {24'h000000, apb_hit ? reg_read(apb_idx, s_q, mode_eff, single_ended) : 8'h00};
      end

      // serial port
      if (par || cs_l) begin
         s_d.spi_cnt   = 4'h0;                                   // [RULE_02]
         s_d.spi_rd    = 1'b0;
         s_d.sdo_drive = 1'b0;
      end else begin
         if (sck_rise) begin
            s_d.spi_sh  = {s_q.spi_sh[6:0], sdi_l};              // [RULE_03] [RULE_20]
            s_d.spi_cnt = s_q.spi_cnt + 4'h1;
            if (s_q.spi_cnt == SPI_HDR_LAST) begin
               s_d.spi_rd   = s_q.spi_sh[6];
               s_d.spi_addr = {s_q.spi_sh[5:0], sdi_l};
            end
            if (s_q.spi_cnt == SPI_BYTE_LAST) begin
               s_d.spi_rd = 1'b0;
               if (!s_q.spi_rd && s_q.spi_addr == REG_CTRL) begin
                  s_d.ctrl = {s_q.spi_sh[6:0], sdi_l};
               end else if (!s_q.spi_rd && s_q.spi_addr == REG_OUTPUT) begin
                  s_d.outr = {s_q.spi_sh[6:0], sdi_l};
               end
            end
         end
         // readback bits change on the falling edge, msb first
         if (sck_fall) begin
            if (s_q.spi_rd && s_q.spi_cnt[3]) begin
               s_d.sdo_drive = ~rb_bit;                                  // [RULE_04]
            end else begin
               s_d.sdo_drive = 1'b0;
            end
         end
      end

      // sample pipeline, one stage per encode cycle; a powered-down part stops converting
      if (enc_rise && power_down == 2'b00) begin
         s_d.p1 = {s_q.p1[PIPE_N-2:0], ch1_sample_in};
         s_d.p2 = {s_q.p2[PIPE_N-2:0], ch2_sample_in};
         s_d.r1 = {s_q.r1[PIPE_N-2:0], ch1_range_in};
         s_d.r2 = {s_q.r2[PIPE_N-2:0], ch2_range_in};
      end

      if (mode_eff == om_full) begin
         if (enc_fall) begin
            s_d.bus1 = s_q.p1[FULL_TAP];                          // [RULE_11] [RULE_12] [RULE_19]
            s_d.bus2 = s_q.p2[FULL_TAP];
            s_d.f1   = s_q.r1[FULL_TAP];                          // [RULE_16]
            s_d.f2   = s_q.r2[FULL_TAP];
         end
      end else begin
         // lanes are read on both encode edges, so the tap is taken before the shift
         for (int i = 0; i < LANES; i++) begin
            if (enc_fall) begin
               s_d.lane1[i] = s_q.p1[DDR_TAP][2*i];               // [RULE_15] [RULE_13] [RULE_19]
               s_d.lane2[i] = s_q.p2[DDR_TAP][2*i];
            end else if (enc_rise) begin
               s_d.lane1[i] = s_q.p1[DDR_TAP][2*i+1];
               s_d.lane2[i] = s_q.p2[DDR_TAP][2*i+1];
            end
         end
         if (enc_fall) begin
            s_d.fs = s_q.r2[DDR_TAP];                             // [RULE_17]
         end else if (enc_rise) begin
            s_d.fs = s_q.r1[DDR_TAP];
         end
      end

      // forwarded clock: encode level delayed by 0..3 pclk cycles behind the data
      s_d.clk_line = {s_q.clk_line[1:0], enc_lvl};
      if (phase == 2'b00) begin
         s_d.fclk = enc_lvl;
      end else begin
         s_d.fclk = s_q.clk_line[2'(phase - 2'b01)];              // [RULE_14]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q      <= '0;
         s_q.ctrl <= CTRL_RESET;
         s_q.outr <= OUTPUT_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata   = s_q.rdata;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~apb_hit;
   assign sdo_o    = 1'b0;                                        // [RULE_05]
   assign sdo_oe_n = ~s_q.sdo_drive;
   assign ch1_sample_bus      = s_q.bus1;
   assign ch2_sample_bus      = s_q.bus2;
   assign ch1_pair_lanes      = s_q.lane1;
   assign ch2_pair_lanes      = s_q.lane2;
   assign ch1_range_flag      = s_q.f1;
   assign ch2_range_flag      = s_q.f2;
   assign shared_range_flag   = s_q.fs;
   assign forwarded_clock_pos = s_q.fclk;
   assign forwarded_clock_neg = ~s_q.fclk;                        // [RULE_12]

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence ser_rise;
      !par && !cs_l && sck_rise;
   endsequence
   sequence full_fall;
      mode_eff == om_full && enc_fall;
   endsequence
   sequence ddr_fall;
      mode_eff != om_full && enc_fall;
   endsequence
   sequence ddr_rise;
      mode_eff != om_full && enc_rise;
   endsequence
   sequence rd_fall;
      !par && !cs_l && sck_fall && s_q.spi_rd && s_q.spi_cnt[3];
   endsequence
   sequence out_byte_rise;
      !par && !cs_l && sck_rise && s_q.spi_cnt == SPI_BYTE_LAST && !s_q.spi_rd && s_q.spi_addr == REG_OUTPUT;
   endsequence

   a_par_no_sdo: assert property (par |=> s_q.sdo_drive == 1'b0 || !$past(par))      // [RULE_01]
      else $error("sdo driven in parallel mode");
   a_sdo_open_drain: assert property (sdo_o == 1'b0)                                  // [RULE_05]
      else $error("sdo drives high");
   a_cs_high_idle: assert property (!par && cs_l |=> s_q.spi_cnt == 4'h0 && !s_q.sdo_drive) // [RULE_02]
      else $error("serial state kept with cs high");
   a_sck_shift: assert property (ser_rise |=> s_q.spi_cnt == $past(s_q.spi_cnt) + 4'h1
                                 && s_q.spi_sh[0] == $past(sdi_l))                    // [RULE_03]
      else $error("sdi bit not captured on sck rise");
   a_par_dcs: assert property (par |-> duty_stabilizer_en == cs_l)                   // [RULE_06]
      else $error("parallel cs does not steer stabilizer");
   a_par_mode: assert property (par && sck_l |-> output_mode == om_ddr_lvds)         // [RULE_07]
      else $error("parallel sck does not select mode");
   a_par_pd: assert property (par |-> power_down == {sdi_l, sdo_l})                  // [RULE_08]
      else $error("parallel power down mismatch");
   a_clk_inverse: assert property (forwarded_clock_neg == ~forwarded_clock_pos)       // [RULE_12]
      else $error("negative output clock not inverse");
   a_full_bus: assert property (full_fall |=> ch1_sample_bus == $past(s_q.p1[FULL_TAP])
                                && ch2_range_flag == $past(s_q.r2[FULL_TAP]))         // [RULE_16]
      else $error("full rate output wrong");
   a_ddr_even: assert property (ddr_fall |=> ch1_pair_lanes[0] == $past(s_q.p1[DDR_TAP][0])
                                && shared_range_flag == $past(s_q.r2[DDR_TAP]))       // [RULE_17]
      else $error("ddr low phase output wrong");
   a_pipe_shift: assert property (enc_rise && power_down == 2'b00 |=>
                                  s_q.p1[0] == $past(ch1_sample_in))                  // [RULE_09]
      else $error("encode edge did not start conversion");
   a_phase0_clk: assert property (!par && phase == 2'b00 && $stable(phase) ##1 $stable(phase)
                                  |-> forwarded_clock_pos == $past(enc_lvl))          // [RULE_14]
      else $error("forwarded clock phase wrong");

   // serial readback, write landing and single-ended encode detect
   a_readback_bit: assert property (rd_fall |=> s_q.sdo_drive == !$past(rb_bit))  // [RULE_04]
      else $error("readback bit wrong");
   a_ser_write: assert property (out_byte_rise |=> s_q.outr[0] == $past(sdi_l)  // [RULE_20]
                                 && s_q.outr[7:1] == $past(s_q.spi_sh[6:0]))
      else $error("serial byte not written");
   a_se_detect: assert property (s_q.sync2[0] |=> !single_ended)  // [RULE_10]
      else $error("single-ended mode with complement high");

   // sample paths
   a_full_ch2: assert property (full_fall |=> ch2_sample_bus == $past(s_q.p2[FULL_TAP])  // [RULE_11]
                                && ch1_range_flag == $past(s_q.r1[FULL_TAP]))
      else $error("full rate channel 2 output wrong");
   a_ddr_odd: assert property (ddr_rise |=> ch2_pair_lanes[6] == $past(s_q.p2[DDR_TAP][13])  // [RULE_15]
                               && shared_range_flag == $past(s_q.r1[DDR_TAP]))
      else $error("ddr high phase output wrong");

   // parallel pins and lvds options
   a_par_full: assert property (par && !sck_l |-> output_mode == om_full)  // [RULE_07]
      else $error("parallel sck low does not select full rate");
   a_term_lvds: assert property (lvds_term_en |-> output_mode == om_ddr_lvds)  // [RULE_18]
      else $error("termination on outside lvds mode");
endmodule // dap_port

// ### core/dap_pkg.sv
// Purpose: shared constants and types for the dual converter output and configuration port
// Assumes: one 125 MHz clock (pclk); every pin is sampled by that clock
// Notes: mode register indices are the serial addresses; the bus byte address is four times the index
package dap_pkg;
   localparam int unsigned SAMPLE_W = 14;
   localparam int unsigned LANES    = 7;
   localparam int unsigned PIPE_N   = 7;
   localparam int unsigned FULL_TAP = 5;   // sample leaves at the 6th encode cycle
   localparam int unsigned DDR_TAP  = 6;   // a whole cycle later in both ddr modes

   // serial frame: read flag, 7-bit address, one data byte, msb first
   localparam logic [3:0] SPI_HDR_LAST = 4'h7;
   localparam logic [3:0] SPI_BYTE_LAST = 4'hf;

   // mode register indices
   localparam logic [6:0] REG_CTRL   = 7'h00;
   localparam logic [6:0] REG_OUTPUT = 7'h01;
   localparam logic [6:0] REG_STATUS = 7'h02;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] OUTPUT_RESET = 8'h00;

   // control register fields
   localparam int unsigned CTRL_PD_LSB = 0;   // [1:0] power down
   localparam int unsigned CTRL_DCS    = 2;   // duty cycle stabilizer enable
   // output register fields
   localparam int unsigned OUT_MODE_LSB  = 0; // [1:0] output mode
   localparam int unsigned OUT_PHASE_LSB = 2; // [3:2] forwarded clock delay, pclk cycles
   localparam int unsigned OUT_CUR_LSB   = 4; // [6:4] lvds drive current code
   localparam int unsigned OUT_TERM      = 7; // internal lvds termination enable

   // cycles ENC- must sit low before single-ended encode is assumed
   localparam logic [5:0] SE_DETECT_CYCLES = 6'h3f;

   typedef enum logic [1:0] {om_full, om_ddr_cmos, om_ddr_lvds} dap_mode_t;
endpackage

// ### sim/dap_host_model.sv
// Purpose: serial configuration host facing the converter port
// Assumes: each serial clock phase lasts 8 pclk, well above the 3 pclk minimum
// Notes: sdo is taken just before each falling serial clock edge of the data byte
`timescale 1ns/1ps
module dap_host_model (
   input  wire logic pclk,
   input  wire logic sdo_line,
   output logic      cs_n,
   output logic      sck,
   output logic      sdi
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      sdi  = 1'b0;
   end
   task automatic half();
      repeat (8) @(posedge pclk);
   endtask
   // fewer than 16 bits cuts the frame short on purpose
   task automatic frame(input logic [15:0] w, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge pclk);
      cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         sdi <= w[15-i];
         half();
         sck <= 1'b1;
         half();
         if (i >= 8) rd = {rd[6:0], sdo_line};
         sck <= 1'b0;
      end
      half();
      cs_n <= 1'b1;
      sdi  <= ~sdi; // released input must not keep its last value
      half();
   endtask
   task automatic pins(input logic c, input logic k, input logic d);
      @(posedge pclk);
      cs_n <= c;
      sck  <= k;
      sdi  <= d;
   endtask
endmodule // dap_host_model

// ### sim/dap_port_test.sv
// Purpose: self-checking bench for the converter configuration and sample port
// Assumes: pclk 8 ns; encode period 16 pclk, far below pclk/6
// Notes: sdo has a pull-up, so a released line reads high
`timescale 1ns/1ps
module dap_port_test;
   import dap_pkg::*;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr, wv, d;
   logic [31:0]         pwdata, prdata;
   logic                program_mode_strap, cs_n, sck, sdi, sdo_o, sdo_oe_n, sdo_line, sdo_drv;
   logic                encode_clock_pos, encode_clock_neg, ch1_range_in, ch2_range_in;
   logic                ch1_range_flag, ch2_range_flag, shared_range_flag, forwarded_clock_pos;
   logic                forwarded_clock_neg, duty_stabilizer_en, lvds_term_en;
   logic [SAMPLE_W-1:0] ch1_sample_in, ch2_sample_in, ch1_sample_bus, ch2_sample_bus;
   logic [LANES-1:0]    ch1_pair_lanes, ch2_pair_lanes;
   logic [1:0]          power_down;
   logic [2:0]          lvds_current;
   dap_mode_t           output_mode, em;
   int                  err_count, compares, ecnt;

   assign sdo_line = sdo_oe_n ? sdo_drv : sdo_o;
   dap_port u_dap_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .program_mode_strap, .cs_n, .sck, .sdi, .sdo_i(sdo_line), .sdo_o, .sdo_oe_n,
      .encode_clock_pos, .encode_clock_neg, .ch1_sample_in, .ch2_sample_in, .ch1_range_in, .ch2_range_in,
      .ch1_sample_bus, .ch2_sample_bus, .ch1_pair_lanes, .ch2_pair_lanes, .ch1_range_flag, .ch2_range_flag,
      .shared_range_flag, .forwarded_clock_pos, .forwarded_clock_neg, .output_mode, .duty_stabilizer_en,
      .power_down, .lvds_current, .lvds_term_en);
   dap_host_model u_dap_host_model (.pclk, .sdo_line, .cs_n, .sck, .sdi);

   function automatic logic [13:0] v1(input int j);
      return 14'(j * 613 + 165);
   endfunction
   function automatic logic [13:0] v2(input int j);
      return ~v1(j) ^ 14'h00f0;
   endfunction
   function automatic logic rg1(input int j);
      return j[0];
   endfunction
   function automatic logic rg2(input int j);
      return (j % 3) == 0;
   endfunction
   function automatic logic [6:0] ev(input logic [13:0] x, input int o);
      logic [6:0] r;
      for (int i = 0; i < 7; i++) r[i] = x[2*i+o];
      return r;
   endfunction
   task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, wd, q, e);
      chk("write error", 32'h0, {31'h0, e});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 8'h00, q, e);
      chk("read data", x, q & m);
      chk("read error", {31'h0, xe}, {31'h0, e});
   endtask
   task automatic test_end(input string n);
      $display("test %s done", n);
   endtask
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // outputs are checked just before each encode edge, once the 3 pclk pin lag has settled
   task automatic run_enc(input int n, input logic se, input dap_mode_t m);
      for (int c = 0; c < n; c++) begin
         repeat (8) @(posedge pclk);
         if (c >= 2 && ecnt >= 9) begin
            chk("clock low", 32'h1, {31'h0, forwarded_clock_pos === 1'b0 && forwarded_clock_neg === 1'b1});
            if (m == om_full) begin
               chk("ch1 bus", 32'(v1(ecnt - 6)), 32'(ch1_sample_bus));
               chk("ch2 bus", 32'(v2(ecnt - 6)), 32'(ch2_sample_bus));
               chk("range flags", {30'h0, rg1(ecnt - 6), rg2(ecnt - 6)}, {30'h0, ch1_range_flag, ch2_range_flag});
            end else begin
               chk("even lanes", {18'h0, ev(v1(ecnt - 7), 0), ev(v2(ecnt - 7), 0)}, {18'h0, ch1_pair_lanes, ch2_pair_lanes});
               chk("flag low", {31'h0, rg2(ecnt - 7)}, {31'h0, shared_range_flag});
            end
         end
         encode_clock_pos <= 1'b1;
         encode_clock_neg <= 1'b0;
         ecnt++;
         repeat (8) @(posedge pclk);
         if (c >= 2 && ecnt >= 9) begin
            chk("clock high", 32'h1, {31'h0, forwarded_clock_pos === 1'b1 && forwarded_clock_neg === 1'b0});
            if (m == om_full) chk("ch1 hold", 32'(v1(ecnt - 7)), 32'(ch1_sample_bus));
            else begin
               chk("odd lanes", {18'h0, ev(v1(ecnt - 8), 1), ev(v2(ecnt - 8), 1)}, {18'h0, ch1_pair_lanes, ch2_pair_lanes});
               chk("flag high", {31'h0, rg1(ecnt - 8)}, {31'h0, shared_range_flag});
            end
         end
         encode_clock_pos <= 1'b0;
         encode_clock_neg <= ~se;
         ch1_sample_in    <= v1(ecnt);
         ch2_sample_in    <= v2(ecnt);
         ch1_range_in     <= rg1(ecnt);
         ch2_range_in     <= rg2(ecnt);
      end
   endtask

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      complete_run();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, program_mode_strap} = '0;
      {err_count, compares, ecnt} = '0;
      sdo_drv = 1'b1;
      encode_clock_pos = 1'b0;
      encode_clock_neg = 1'b1;
      ch1_sample_in = v1(0);
      ch2_sample_in = v2(0);
      ch1_range_in = rg1(0);
      ch2_range_in = rg2(0);
      repeat (3) @(posedge pclk);
      chk("reset clock pair", 32'h1, {31'h0, forwarded_clock_neg});
      presetn <= 1'b1;
      rd(8'h00, 32'hffffffff, {24'h0, CTRL_RESET}, 1'b0);
      rd(8'h04, 32'hffffffff, {24'h0, OUTPUT_RESET}, 1'b0);
      rd(8'h0c, 32'hffffffff, 32'h0, 1'b1);
      rd(8'h02, 32'hffffffff, 32'h0, 1'b1);
      test_end("reset and map");
      u_dap_host_model.frame({1'b0, REG_OUTPUT, 8'hb5}, 16, d);
      rd(8'h04, 32'hff, 32'hb5, 1'b0);
      chk("serial mode", 32'(om_ddr_cmos), 32'(output_mode));
      u_dap_host_model.frame({1'b1, REG_OUTPUT, 8'h00}, 16, d);
      chk("readback", 32'hb5, {24'h0, d});
      chk("sdo released", 32'h1, {31'h0, sdo_oe_n});
      chk("sdo pulls low only", 32'h0, {31'h0, sdo_o});
      u_dap_host_model.frame({1'b0, REG_OUTPUT, 8'h00}, 12, d);
      u_dap_host_model.frame({1'b0, REG_CTRL, 8'h07}, 16, d);
      rd(8'h04, 32'hff, 32'hb5, 1'b0);
      chk("control", 32'h7, {29'h0, duty_stabilizer_en, power_down});
      wr(8'h00, 8'h00);
      test_end("serial port");
      for (int m = 0; m < 4; m++) begin
         wv = {m[1], 3'(m + 1), m[1:0], m[1:0]};
         em = (m == 1) ? om_ddr_cmos : (m == 2) ? om_ddr_lvds : om_full;
         wr(8'h04, wv);
         rd(8'h04, 32'hff, {24'h0, wv}, 1'b0);
         chk("lvds config", {28'h0, wv[6:4], wv[7] & (em == om_ddr_lvds)}, {28'h0, lvds_current, lvds_term_en});
         chk("output mode", 32'(em), 32'(output_mode));
         run_enc(12, 1'b0, em);
      end
      wr(8'h04, 8'h00);
      run_enc(10, 1'b1, om_full);
      rd(8'h08, 32'h3, 32'h2, 1'b0);
      run_enc(2, 1'b0, om_full);
      test_end("sample paths");
      program_mode_strap <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         u_dap_host_model.pins(k[0], k[0], k[0]);
         sdo_drv <= k[0];
         repeat (8) @(posedge pclk);
         chk("parallel mode", 32'(k ? om_ddr_lvds : om_full), 32'(output_mode));
         chk("stabilizer follows cs", {31'h0, k[0]}, {31'h0, duty_stabilizer_en});
         chk("power down follows pins", {30'h0, k[0], k[0]}, {30'h0, power_down});
      end
      rd(8'h08, 32'h1, 32'h1, 1'b0);
      test_end("parallel pins");
      complete_run();
   end
endmodule // dap_port_test
